/* File: src/mmn_pkg.sv */
// shared constants and types for the move/multiply/negate execute block
package mmn_pkg;

	// opcode fields of the instruction word
	localparam logic [7:0] OPC_STORE_WORKING = 8'h01;
	localparam logic [7:0] OPC_MULTIPLY_IMMEDIATE = 8'hBC;
	localparam logic [7:0] OPC_MULTIPLY_FILE = 8'h34;
	localparam logic [6:0] OPC_NEGATE_WORKING = 7'h16;
	localparam logic [2:0] OPC_MOVE_LOW_PAGE = 3'h2;

	// field positions inside the instruction word
	localparam int OPC_BYTE_LSB = 8;
	localparam int NEG_OPC_LSB = 9;
	localparam int NEG_SELECT_BIT = 8;
	localparam int PAGE_OPC_LSB = 13;
	localparam int PAGE_SRC_LSB = 8;
	localparam int PAGE_SRC_W = 5;

	// reset values
	localparam logic [7:0] WORKING_RESET = 8'h00;
	localparam logic [7:0] PRODUCT_RESET = 8'h00;
	localparam logic [7:0] FILE_ADDR_RESET = 8'h00;

	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mmn_phase_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_STORE,
		OP_MUL_IMM,
		OP_MUL_FILE,
		OP_NEGATE,
		OP_MOVE_PAGE
	} mmn_op_t;

	typedef struct packed {
		logic ov;
		logic c;
		logic dc;
		logic z;
	} mmn_flags_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} mmn_file_wr_t;

	typedef struct packed {
		logic en;
		mmn_flags_t mask;
		mmn_flags_t value;
	} mmn_flag_wr_t;

	typedef struct packed {
		mmn_phase_t phase;
		mmn_op_t op;
		logic neg_sel;
		logic [7:0] f_addr;
		logic [7:0] p_addr;
		logic [7:0] operand;
		logic [7:0] working_register;
		logic [7:0] prod_hi;
		logic [7:0] prod_lo;
		mmn_file_wr_t file_wr;
		mmn_flag_wr_t flag_wr;
	} mmn_state_t;

endpackage : mmn_pkg

/* File: src/mmn_multiplier.sv */
// unsigned multiplier for the product register pair
`timescale 1ns/1ps
`default_nettype none
module mmn_multiplier #(
	parameter int W = 8
) (
	// operands
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	// full-width product, never overflows
	output logic [2*W-1:0] product
);

	assign product = {{W{1'b0}}, a} * {{W{1'b0}}, b};

endmodule : mmn_multiplier
`default_nettype wire

/* File: src/mmn_negate.sv */
// two's complement of the working register with its flags
`timescale 1ns/1ps
`default_nettype none
module mmn_negate
	import mmn_pkg::*;
(
	// value to negate
	input wire logic [7:0] work,
	// result and flags of inverse plus one
	output logic [7:0] result,
	output mmn_flags_t flags
);

	logic [7:0] inv;
	logic [8:0] sum;
	logic [4:0] low;

	assign inv = ~work;
	// done as a real add so carry and digit carry fall out naturally
	assign sum = {1'b0, inv} + 9'h001;
	assign low = {1'b0, inv[3:0]} + 5'h01;
	assign result = sum[7:0];
	assign flags.c = sum[8];
	assign flags.dc = low[4];
	assign flags.z = (sum[7:0] == 8'h00);
	// positive plus one turning negative
	assign flags.ov = ~inv[7] & sum[7];

endmodule : mmn_negate
`default_nettype wire

/* File: src/mmn_exec.sv */
// decode and execute of store, multiply, negate and low-page move
//
// Contract
// - storing the working register copies it to any file address, keeping it and all flags.
// - upper byte 1011 1100 multiplies the working register by the low-byte immediate, unsigned.
// - the immediate multiply puts its 16-bit product high byte to product_high, low to product_low, keeping the working register.
// - neither multiply touches any status flag, with no carry, overflow or zero indication.
// - the file multiply multiplies the working register by the file location at an 8-bit address, unsigned.
// - the file multiply stores its 16-bit product in the pair, high byte high, keeping the working register and the file location.
// - upper byte 0011 0100 decodes as the file multiply with the low byte as file address.
// - a build without the multiplier does not decode either multiply.
// - negate produces the inverse of the working register plus one.
// - with select bit 0 negate writes the result to the working register and the file location.
// - with select bit 1 negate writes the result only to the file location.
// - the low-page move copies a source at 00h to 1Fh to any destination and updates zero.
`timescale 1ns/1ps
`default_nettype none
module mmn_exec
	import mmn_pkg::*;
#(
	parameter bit HAS_MULTIPLIER = 1'b1,
	parameter logic [7:0] WORK_FILE_ADDR = 8'h0A
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// instruction from fetch
	input wire logic INSTR_VALID,
	input wire logic [15:0] INSTR_WORD,
	output logic INSTR_TAKEN,
	output logic INSTR_FOREIGN,
	// working register load by other instructions
	input wire logic WORK_LOAD_EN,
	input wire logic [7:0] WORK_LOAD_DATA,
	// register file read port
	output logic FILE_RD_EN,
	output logic [7:0] FILE_RD_ADDR,
	input wire logic [7:0] FILE_RD_DATA,
	// register file write port
	output mmn_file_wr_t FILE_WR,
	// status flag update
	output mmn_flag_wr_t FLAG_WR,
	// architectural state
	output logic [7:0] WORKING_REGISTER,
	output logic [7:0] PRODUCT_HIGH,
	output logic [7:0] PRODUCT_LOW,
	output mmn_phase_t PHASE
);

	localparam mmn_state_t STATE_RESET = '{
		phase: PH_Q1,
		op: OP_NONE,
		neg_sel: 1'b0,
		f_addr: FILE_ADDR_RESET,
		p_addr: FILE_ADDR_RESET,
		operand: WORKING_RESET,
		working_register: WORKING_RESET,
		prod_hi: PRODUCT_RESET,
		prod_lo: PRODUCT_RESET,
		file_wr: '0,
		flag_wr: '0
	};

	mmn_state_t s_r;
	mmn_state_t s_nxt;
	mmn_op_t dec_op;
	logic [15:0] product;
	logic [7:0] neg_result;
	mmn_flags_t neg_flags;
	logic [7:0] rd_addr;
	logic rd_needed;

	// opcode recognition; multiplies vanish without the multiplier
	always_comb begin
		dec_op = OP_NONE;
		if (INSTR_WORD[15:OPC_BYTE_LSB] == OPC_STORE_WORKING) begin
			dec_op = OP_STORE;
		end else if (INSTR_WORD[15:OPC_BYTE_LSB] == OPC_MULTIPLY_IMMEDIATE
			&& HAS_MULTIPLIER) begin
			dec_op = OP_MUL_IMM;
		end else if (INSTR_WORD[15:OPC_BYTE_LSB] == OPC_MULTIPLY_FILE
			&& HAS_MULTIPLIER) begin
			dec_op = OP_MUL_FILE;
		end else if (INSTR_WORD[15:NEG_OPC_LSB] == OPC_NEGATE_WORKING) begin
			dec_op = OP_NEGATE;
		end else if (INSTR_WORD[15:PAGE_OPC_LSB] == OPC_MOVE_LOW_PAGE) begin
			dec_op = OP_MOVE_PAGE;
		end
	end

	// a Q1 slot is only offered to this block; anything else is passed on
	assign INSTR_TAKEN = (s_r.phase == PH_Q1) && INSTR_VALID
		&& (dec_op != OP_NONE);
	assign INSTR_FOREIGN = (s_r.phase == PH_Q1) && INSTR_VALID
		&& (dec_op == OP_NONE);

	// the immediate multiply reads nothing; the rest read in Q2
	assign rd_needed = (s_r.op == OP_STORE) || (s_r.op == OP_MUL_FILE)
		|| (s_r.op == OP_NEGATE) || (s_r.op == OP_MOVE_PAGE);
	assign rd_addr = (s_r.op == OP_MOVE_PAGE) ? s_r.p_addr : s_r.f_addr;
	assign FILE_RD_EN = (s_r.phase == PH_Q2) && rd_needed;
	assign FILE_RD_ADDR = rd_addr;

	// multiplier fed from registered operands so Q3 sees stable inputs
	mmn_multiplier #(
		.W(8)
	) u_mul (
		.a(s_r.working_register),
		.b(s_r.operand),
		.product(product)
	);

	mmn_negate u_neg (
		.work(s_r.working_register),
		.result(neg_result),
		.flags(neg_flags)
	);

	always_comb begin
		s_nxt = s_r;
		// write strobes live for exactly the Q4 phase
		s_nxt.file_wr.en = 1'b0;
		s_nxt.flag_wr.en = 1'b0;
		case (s_r.phase)
			PH_Q1: begin
				s_nxt.phase = PH_Q2;
				s_nxt.op = INSTR_VALID ? dec_op : OP_NONE;
				s_nxt.f_addr = INSTR_WORD[7:0];
				s_nxt.p_addr = {3'h0,
					INSTR_WORD[PAGE_SRC_LSB +: PAGE_SRC_W]};
				s_nxt.neg_sel = INSTR_WORD[NEG_SELECT_BIT];
				// immediate sits where a file address would
				s_nxt.operand = INSTR_WORD[7:0];
			end
			PH_Q2: begin
				s_nxt.phase = PH_Q3;
				if (rd_needed) begin
					// the working register is mapped into the file space
					s_nxt.operand = (rd_addr == WORK_FILE_ADDR) ?
						s_r.working_register : FILE_RD_DATA;
				end
			end
			PH_Q3: begin
				s_nxt.phase = PH_Q4;
				case (s_r.op)
					OP_STORE: begin
						s_nxt.file_wr = '{en: 1'b1, addr: s_r.f_addr,
							data: s_r.working_register};
					end
					OP_MUL_IMM, OP_MUL_FILE: begin
						// no file or flag write: source and flags stay
						s_nxt.prod_hi = product[15:8];
						s_nxt.prod_lo = product[7:0];
					end
					OP_NEGATE: begin
						s_nxt.file_wr = '{en: 1'b1, addr: s_r.f_addr,
							data: neg_result};
						if (!s_r.neg_sel || s_r.f_addr == WORK_FILE_ADDR) begin
							s_nxt.working_register = neg_result;
						end
						s_nxt.flag_wr.en = 1'b1;
						s_nxt.flag_wr.mask = '{ov: 1'b1, c: 1'b1, dc: 1'b1,
							z: 1'b1};
						s_nxt.flag_wr.value = neg_flags;
					end
					OP_MOVE_PAGE: begin
						s_nxt.file_wr = '{en: 1'b1, addr: s_r.f_addr,
							data: s_r.operand};
						if (s_r.f_addr == WORK_FILE_ADDR) begin
							s_nxt.working_register = s_r.operand;
						end
						s_nxt.flag_wr.en = 1'b1;
						s_nxt.flag_wr.mask = '{ov: 1'b0, c: 1'b0, dc: 1'b0,
							z: 1'b1};
						s_nxt.flag_wr.value = '{ov: 1'b0, c: 1'b0, dc: 1'b0,
							z: (s_r.operand == 8'h00)};
					end
					default: begin
						s_nxt.op = OP_NONE;
					end
				endcase
			end
			PH_Q4: begin
				s_nxt.phase = PH_Q1;
				s_nxt.op = OP_NONE;
			end
			default: begin
				s_nxt.phase = PH_Q1;
				s_nxt.op = OP_NONE;
			end
		endcase
		// other instructions own the working register outside this group
		if (WORK_LOAD_EN) begin
			s_nxt.working_register = WORK_LOAD_DATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			s_r <= STATE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign FILE_WR = s_r.file_wr;
	assign FLAG_WR = s_r.flag_wr;
	assign WORKING_REGISTER = s_r.working_register;
	assign PRODUCT_HIGH = s_r.prod_hi;
	assign PRODUCT_LOW = s_r.prod_lo;
	assign PHASE = s_r.phase;

endmodule : mmn_exec
`default_nettype wire

/* File: verif/mmn_exec_asserts.sv */
// timing and result checker for the execute block
`timescale 1ns/1ps
`default_nettype none
module mmn_exec_asserts
	import mmn_pkg::*;
#(
	parameter bit HAS_MULTIPLIER = 1'b1,
	parameter logic [7:0] WORK_FILE_ADDR = 8'h0A
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// instruction
	input wire logic INSTR_VALID,
	input wire logic [15:0] INSTR_WORD,
	input wire logic INSTR_TAKEN,
	// file, flags and state
	input wire logic FILE_RD_EN,
	input wire logic [7:0] FILE_RD_ADDR,
	input wire logic [7:0] FILE_RD_DATA,
	input wire mmn_file_wr_t FILE_WR,
	input wire mmn_flag_wr_t FLAG_WR,
	input wire logic [7:0] WORKING_REGISTER,
	input wire logic [7:0] PRODUCT_HIGH,
	input wire logic [7:0] PRODUCT_LOW,
	input wire mmn_phase_t PHASE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	wire logic [7:0] op = INSTR_WORD[15:8];
	wire logic [7:0] lo = INSTR_WORD[7:0];
	// alias reads return the working register, not the file data
	wire logic nal = lo != WORK_FILE_ADDR;
	wire logic ng = INSTR_TAKEN && INSTR_WORD[15:9] == OPC_NEGATE_WORKING;
	wire logic [15:0] prod = {PRODUCT_HIGH, PRODUCT_LOW};
	wire logic [15:0] w16 = {8'h00, WORKING_REGISTER};
	a_phase_cycle: assert property (PHASE == PH_Q1 |=>
		PHASE == PH_Q2 ##1 PHASE == PH_Q3 ##1 PHASE == PH_Q4 ##1 PHASE == PH_Q1)
		else $error("phase order wrong");
	a_strobe_q4: assert property ((FILE_WR.en || FLAG_WR.en) |->
		PHASE == PH_Q4) else $error("write strobe outside Q4");
	a_store_copy: assert property (INSTR_TAKEN && op == OPC_STORE_WORKING
		|=> FILE_RD_EN ##2 FILE_WR.en && !FLAG_WR.en &&
		FILE_WR.addr == $past(lo, 3) && FILE_WR.data == WORKING_REGISTER)
		else $error("store wrong");
	a_mul_imm: assert property (INSTR_TAKEN && op == OPC_MULTIPLY_IMMEDIATE
		|-> ##3 prod == $past(w16 * {8'h00, lo}, 3) && !FLAG_WR.en &&
		WORKING_REGISTER == $past(WORKING_REGISTER, 3))
		else $error("immediate product wrong");
	a_mul_file: assert property (INSTR_TAKEN && op == OPC_MULTIPLY_FILE && nal
		|=> FILE_RD_EN && FILE_RD_ADDR == $past(lo) ##2 !FILE_WR.en &&
		!FLAG_WR.en && prod == $past(w16 * {8'h00, FILE_RD_DATA}, 2))
		else $error("file product wrong");
	a_neg_value: assert property (ng |-> ##3 FILE_WR.en &&
		FILE_WR.data == ~$past(WORKING_REGISTER, 3) + 8'h01 &&
		FLAG_WR.mask == 4'hF && FLAG_WR.value.z == (FILE_WR.data == 8'h00) &&
		FLAG_WR.value.c == ($past(WORKING_REGISTER, 3) == 8'h00))
		else $error("negate result wrong");
	a_neg_dest: assert property (ng && nal |-> ##3 WORKING_REGISTER ==
		($past(INSTR_WORD[8], 3) ? $past(WORKING_REGISTER, 3) : FILE_WR.data))
		else $error("negate destination wrong");
	a_move_zero: assert property (INSTR_TAKEN && INSTR_WORD[15:13] == 3'h2
		|=> FILE_RD_ADDR == {3'b000, $past(INSTR_WORD[12:8])} ##2 FILE_WR.en &&
		FLAG_WR.mask == 4'h1 && FLAG_WR.value.z == (FILE_WR.data == 8'h00))
		else $error("move wrong");
	cover property (ng ##3 FLAG_WR.value.c);
	cover property (INSTR_TAKEN ##4 INSTR_TAKEN);
	cover property (INSTR_VALID && PHASE == PH_Q1 && !INSTR_TAKEN);
endmodule : mmn_exec_asserts
bind mmn_exec mmn_exec_asserts #(.HAS_MULTIPLIER(HAS_MULTIPLIER),
	.WORK_FILE_ADDR(WORK_FILE_ADDR)) chk_u (.CLK, .RESET, .INSTR_VALID,
	.INSTR_WORD, .INSTR_TAKEN, .FILE_RD_EN, .FILE_RD_ADDR, .FILE_RD_DATA,
	.FILE_WR, .FLAG_WR, .WORKING_REGISTER, .PRODUCT_HIGH, .PRODUCT_LOW, .PHASE);
`default_nettype wire

/* File: verif/mmn_exec_bench.sv */
// self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
module mmn_exec_bench;
	import mmn_pkg::*;
	logic CLK = 0, RESET = 1, vld = 0, ld = 0;
	logic [15:0] wd = 0, prod = 0;
	logic [7:0] ldv = 0, rdd = 0, working_register = 0;
	int n_fail = 0, num_checks = 0;
	wire logic tk, fr, rde, rtk, rfr;
	wire logic [7:0] rda, w, ph, pl, rw, rph, rpl;
	wire mmn_file_wr_t fw;
	wire mmn_flag_wr_t fl;
	wire mmn_phase_t phs;
	logic [7:0] hs [6] = '{8'h01, 8'hBC, 8'h34, 8'h2C, 8'h40, 8'hE0};
	logic [7:0] hm [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h1F, 8'h1F};
	// working_register load, opcode+operand, file data
	logic [31:0] tb [10] = '{32'h4F01_33FF, 32'hE2BC_C400, 32'hC434_20B5,
		32'h3A2C_20AB, 32'h802D_2100, 32'h002C_0A00, 32'h00BC_0000,
		32'h9900_0000, 32'h775F_4000, 32'h5534_0A00};
	always #2.5 CLK = ~CLK;
	mmn_exec dut_u (.CLK, .RESET, .INSTR_VALID(vld), .INSTR_WORD(wd),
		.INSTR_TAKEN(tk), .INSTR_FOREIGN(fr), .WORK_LOAD_EN(ld),
		.WORK_LOAD_DATA(ldv), .FILE_RD_EN(rde), .FILE_RD_ADDR(rda),
		.FILE_RD_DATA(rdd), .FILE_WR(fw), .FLAG_WR(fl), .WORKING_REGISTER(w),
		.PRODUCT_HIGH(ph), .PRODUCT_LOW(pl), .PHASE(phs));
	mmn_exec #(.HAS_MULTIPLIER(1'b0)) dut_r (.CLK, .RESET, .INSTR_VALID(vld),
		.INSTR_WORD(wd), .INSTR_TAKEN(rtk), .INSTR_FOREIGN(rfr),
		.WORK_LOAD_EN(ld), .WORK_LOAD_DATA(ldv), .FILE_RD_EN(),
		.FILE_RD_ADDR(), .FILE_RD_DATA(rdd), .FILE_WR(), .FLAG_WR(),
		.WORKING_REGISTER(rw), .PRODUCT_HIGH(rph), .PRODUCT_LOW(rpl), .PHASE());
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic load(logic [7:0] v);
		@(posedge CLK);
		ld <= 1;
		ldv <= v;
		@(posedge CLK);
		ld <= 0;
		working_register = v;
		@(negedge CLK);
	endtask : load
	task automatic ex(logic [15:0] i, logic [7:0] d);
		logic g, mi, mf, ng, mv;
		logic [7:0] a, dv, r;
		logic [16:0] ew;
		logic [8:0] ef;
		int t;
		mi = i[15:8] == OPC_MULTIPLY_IMMEDIATE;
		mf = i[15:8] == OPC_MULTIPLY_FILE;
		ng = i[15:9] == OPC_NEGATE_WORKING;
		mv = i[15:13] == OPC_MOVE_LOW_PAGE;
		g = i[15:8] == OPC_STORE_WORKING || ng || mv;
		a = mv ? {3'b000, i[12:8]} : i[7:0];
		dv = a == 8'h0A ? working_register : d;
		r = ~working_register + 8'h01;
		t = 0;
		while (phs !== PH_Q4) begin
			@(negedge CLK);
			if (++t > 9) begin
				n_fail++;
				complete_run();
			end
		end
		@(posedge CLK);
		vld <= 1;
		wd <= i;
		@(negedge CLK);
		chk("decode", {tk, fr, rtk, rfr}, {g | mf | mi, !(g | mf | mi), g, !g});
		@(posedge CLK);
		// junk with valid high outside Q1 must be ignored
		wd <= 16'($urandom);
		rdd <= d;
		@(negedge CLK);
		chk("read", {rde, rde ? rda : 8'h00}, {g | mf, g | mf ? a : 8'h00});
		@(posedge CLK);
		rdd <= ~d;
		@(posedge CLK);
		vld <= 0;
		@(negedge CLK);
		ew = {i[15:8] == OPC_STORE_WORKING, i[7:0], working_register};
		ef = 0;
		if (mi)
			prod = working_register * i[7:0];
		if (mf)
			prod = working_register * dv;
		if (ng) begin
			ew = {1'b1, i[7:0], r};
			ef = {5'h1F, working_register[7] & r[7], working_register == 0, working_register[3:0] == 0, r == 0};
			if (!i[8])
				working_register = r;
		end
		if (mv) begin
			ew = {1'b1, i[7:0], dv};
			ef = {5'h11, 3'b000, dv == 0};
		end
		if (ew[16] && ew[15:8] == 8'h0A)
			working_register = ew[7:0];
		if (!ew[16])
			ew = 0;
		chk("file_wr", {fw.en, fw.en ? {fw.addr, fw.data} : 16'h0}, ew);
		// mask and value hold stale bits once the strobe drops
		chk("flag_wr", {fl.en, fl.en ? {fl.mask, fl.value & fl.mask} : 8'h00}, ef);
		chk("state", {w, ph, pl}, {working_register, prod});
		chk("reduced", {rw, rph, rpl}, {working_register, 16'h0000});
	endtask : ex
	initial begin
		int k;
		void'($urandom(56));
		repeat (8) @(posedge CLK);
		RESET <= 0;
		@(negedge CLK);
		chk("reset", {phs, fw.en, fl.en, w, ph, pl}, 0);
		foreach (tb[j]) begin
			load(tb[j][31:24]);
			ex(tb[j][23:8], tb[j][7:0]);
		end
		repeat (80) begin
			k = $urandom % 6;
			if ($urandom % 3 == 0)
				load(8'($urandom));
			ex({hs[k] | (hm[k] & 8'($urandom)), 8'($urandom)}, 8'($urandom));
		end
		complete_run();
	end
endmodule : mmn_exec_bench
`default_nettype wire
